// File: bcirq_host.sv
// Purpose: Host model on the register port
// Assumes: Strobes held one full cycle
// Notes:   Changes only at falling edges
`timescale 1ns/1ps
`default_nettype none
module bcirq_host (
   input  wire logic        clk,
   output logic      [7:0]  addr,
   output logic             wr,
   output logic             rd,
   output logic      [15:0] wdata);
   initial begin
      {addr, wr, rd, wdata} = '0;
   end
   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(negedge clk) {addr, wdata, wr, rd} = {a, d, w, !w};
      @(negedge clk) {wr, rd, wdata} = {2'b00, ~d};
   endtask
endmodule
`default_nettype wire

// File: bcirq_monitor.sv
// Purpose: Port checks of bcirq_regs
// Assumes: One clock, reset high
// Notes:   Bound to every instance
`timescale 1ns/1ps
`default_nettype none
module bcirq_monitor (
   input wire logic I_CLOCK, I_RST, I_RD, I_FRAME_TIMER_EXPIRED, I_MSG_DONE,
   input wire logic I_GPQ_PTR_ADVANCE, I_OTHER_IRQ, O_LOG_WRITE, O_IRQ,
   input wire logic O_CONTROLLER_SUMMARY_PENDING,
   input wire logic [7:0]  I_ADDR,
   input wire logic [15:0] O_RDATA, O_LOG_BITS,
   input wire logic [12:0] I_OTHER_EVENTS);
   // Any event input, and a pending read
   wire ev  = I_FRAME_TIMER_EXPIRED | I_MSG_DONE | I_GPQ_PTR_ADVANCE | (|I_OTHER_EVENTS);
   wire rdp = I_RD && I_ADDR == 8'h07;
   wire sp  = O_CONTROLLER_SUMMARY_PENDING;
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);
   a_other_irq_or: assert property (I_OTHER_IRQ |-> O_IRQ)
      else $error("irq lost");
   a_log_has_bits: assert property (O_LOG_WRITE |-> O_LOG_BITS != 0)
      else $error("empty log");
   a_log_has_cause: assert property (O_LOG_WRITE |-> $past(ev))
      else $error("log no event");
   a_sum_with_log: assert property (O_LOG_WRITE |-> sp)
      else $error("no summary");
   a_read_nonzero: assert property (rdp && sp |=> O_RDATA != 0)
      else $error("bad read");
   a_irq_at_done: assert property ($rose(O_IRQ) && !I_OTHER_IRQ |-> $past(I_MSG_DONE))
      else $error("early irq");
   a_irq_needs_pend: assert property (O_IRQ && !I_OTHER_IRQ |-> sp || $past(sp))
      else $error("stale irq");
   a_rdata_holds: assert property (!$past(I_RD) |-> $stable(O_RDATA))
      else $error("rdata moved");
endmodule
bind bcirq_regs bcirq_monitor mon_u (.*);
`default_nettype wire

// File: bcirq_pkg.sv
// Purpose: Constants for the controller interrupt register block
// Assumes: 16-bit host register port, word offsets
// Notes:   Bits 12..0 are carried as generic event inputs
package bcirq_pkg;
   localparam int          BCIRQ_W           = 16;
   localparam int          BCIRQ_AW          = 8;
   localparam logic [7:0]  BCIRQ_OFS_PENDING = 8'h07;
   localparam logic [7:0]  BCIRQ_OFS_ENABLE  = 8'h10;
   localparam logic [7:0]  BCIRQ_OFS_OUTEN   = 8'h14;
   localparam logic [15:0] BCIRQ_RST_VAL     = 16'h0000;
   localparam int          BCIRQ_BIT_FRAME   = 15;
   localparam int          BCIRQ_BIT_SELECTED = 14;
   localparam int          BCIRQ_BIT_GPQ     = 13;
   localparam int          BCIRQ_END_SEL_BIT = 4;
   localparam int          BCIRQ_GPQ_DEPTH   = 64;
endpackage

// File: bcirq_regs.sv
// Purpose: Enable, pending and output-enable registers of the bus controller
// Assumes: Events are one-cycle pulses synchronous to I_CLOCK
// Notes:   Interrupt output is raised at message completion, or at once by I_OTHER_IRQ
//
// Functional notes
// - An event source is enabled only while its enable bit is one.
// - Disabled events set no pending bit, no log entry, no interrupt.
// - Events before enabling are never recognised afterwards.
// - Enabled events set pending bit and pulse a log-buffer write.
// - Any new pending bit sets the summary pending output bit.
// - Interrupt output asserts at message completion, not at event time.
// - Events without output enable update pending, summary and log only.
// - One bit position means the same event in all three registers.
// - Bit 15 is the frame timer expiry event.
// - Bit 14 is completion of a message with end-of-message select.
// - Bit 13 is the 64-word queue pointer wrapping to base.
// - Reading the pending register returns it, then clears it.
// - New events are ORed into pending, keeping earlier bits.
// - One shared interrupt output, combined with other gated sources.
`timescale 1ns/1ps
`default_nettype none
module bcirq_regs
   import bcirq_pkg::*;
#(
   parameter int GPQ_DEPTH = BCIRQ_GPQ_DEPTH
) (
   input  wire logic                I_CLOCK,
   input  wire logic                I_RST,
   input  wire logic [BCIRQ_AW-1:0] I_ADDR,
   input  wire logic                I_WR,
   input  wire logic                I_RD,
   input  wire logic [BCIRQ_W-1:0]  I_WDATA,
   output logic      [BCIRQ_W-1:0]  O_RDATA,
   input  wire logic                I_FRAME_TIMER_EXPIRED,
   input  wire logic                I_MSG_DONE,
   input  wire logic [BCIRQ_W-1:0]  I_MSG_CTRL_WORD,
   input  wire logic                I_GPQ_PTR_ADVANCE,
   input  wire logic [12:0]         I_OTHER_EVENTS,
   input  wire logic                I_OTHER_IRQ,
   output logic                     O_LOG_WRITE,
   output logic      [BCIRQ_W-1:0]  O_LOG_BITS,
   output logic                     O_CONTROLLER_SUMMARY_PENDING,
   output logic                     O_IRQ
);

   ////////////////////////////////////////////////////////////////////
   // Local sizes
   // Pointer width follows the queue depth, so a shortened queue still wraps
   localparam int               PTR_W    = (GPQ_DEPTH > 1) ? $clog2(GPQ_DEPTH) : 1;
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(GPQ_DEPTH - 1);
   localparam logic [PTR_W-1:0] PTR_STEP = PTR_W'(1);
   localparam logic [PTR_W-1:0] PTR_BASE = '0;
   // Generic event inputs fill the bits below the queue wrap bit
   localparam int               OTHER_W  = BCIRQ_BIT_GPQ;

   ////////////////////////////////////////////////////////////////////
   // Configuration and status storage
   logic [BCIRQ_W-1:0] enable_r;
   logic [BCIRQ_W-1:0] outen_r;
   logic [BCIRQ_W-1:0] pending_r;
   logic [BCIRQ_W-1:0] rdata_r;
   logic [PTR_W-1:0]   gpq_ptr_r;
   logic               irq_r;
   logic               summary_r;
   logic               log_wr_r;
   logic [BCIRQ_W-1:0] log_bits_r;

   // Next values and decoded strobes
   logic [BCIRQ_W-1:0] pending_nxt;
   logic [BCIRQ_W-1:0] pend_keep;
   logic [BCIRQ_W-1:0] rdata_nxt;
   logic [PTR_W-1:0]   gpq_ptr_nxt;
   logic               irq_nxt;
   logic               summary_nxt;
   logic               log_wr_nxt;
   logic [BCIRQ_W-1:0] raw_ev;
   logic [BCIRQ_W-1:0] ev;
   logic               sel_pend;
   logic               sel_en;
   logic               sel_oe;
   logic               wr_en;
   logic               wr_oe;
   logic               rd_pend;
   logic               gpq_last;
   logic               gpq_wrap;
   logic               sel_msg_done;
   logic               hi_pend;

   ////////////////////////////////////////////////////////////////////
   // Register hit, shared by the write and the read paths
   function automatic logic reg_hit(input logic [BCIRQ_AW-1:0] addr,
                                    input logic [BCIRQ_AW-1:0] ofs);
      reg_hit = (addr == ofs);
   endfunction

   // Register decode
   assign sel_pend = reg_hit(I_ADDR, BCIRQ_OFS_PENDING);
   assign sel_en   = reg_hit(I_ADDR, BCIRQ_OFS_ENABLE);
   assign sel_oe   = reg_hit(I_ADDR, BCIRQ_OFS_OUTEN);

   // Qualified strobes; writes to the pending register fall through unused
   assign wr_en   = I_WR & sel_en;
   assign wr_oe   = I_WR & sel_oe;
   assign rd_pend = I_RD & sel_pend;

   ////////////////////////////////////////////////////////////////////
   // Queue pointer: wraps from its last word back to base
   assign gpq_last    = (gpq_ptr_r == PTR_LAST);
   assign gpq_wrap    = I_GPQ_PTR_ADVANCE & gpq_last;
   assign gpq_ptr_nxt = !I_GPQ_PTR_ADVANCE ? gpq_ptr_r :
                        gpq_last           ? PTR_BASE  : gpq_ptr_r + PTR_STEP;

   ////////////////////////////////////////////////////////////////////
   // shared bit map
   assign sel_msg_done               = I_MSG_DONE & I_MSG_CTRL_WORD[BCIRQ_END_SEL_BIT];
   assign raw_ev[BCIRQ_BIT_FRAME]    = I_FRAME_TIMER_EXPIRED;
   assign raw_ev[BCIRQ_BIT_SELECTED] = sel_msg_done;
   assign raw_ev[BCIRQ_BIT_GPQ]      = gpq_wrap;
   assign raw_ev[OTHER_W-1:0]        = I_OTHER_EVENTS;

   ////////////////////////////////////////////////////////////////////
   // enable gating
   // OR into pending
   // Raw events are never stored, so a late enable sees no history
   // Set wins over the read clear in the same cycle, so no event is lost
   for (genvar gi = 0; gi < BCIRQ_W; gi++) begin : g_bit
      assign ev[gi]          = raw_ev[gi] & enable_r[gi];
      assign pend_keep[gi]   = rd_pend ? 1'b0 : pending_r[gi];
      assign pending_nxt[gi] = pend_keep[gi] | ev[gi];
   end

   ////////////////////////////////////////////////////////////////////
   // summary pending bit
   // Summary follows the pending word, so it clears once pending is read empty
   assign summary_nxt = |pending_nxt;

   assign log_wr_nxt = |ev;

   assign hi_pend = |(pending_nxt & outen_r);
   assign irq_nxt = !hi_pend   ? 1'b0 :
                    I_MSG_DONE ? 1'b1 : irq_r;

   // Read data is captured on the read edge and stands until the next read
   // Unmapped addresses read zero
   assign rdata_nxt = !I_RD    ? rdata_r   :
                      sel_pend ? pending_r :
                      sel_en   ? enable_r  :
                      sel_oe   ? outen_r   : BCIRQ_RST_VAL;

   ////////////////////////////////////////////////////////////////////
   // Host-written configuration
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         enable_r <= BCIRQ_RST_VAL;
         outen_r  <= BCIRQ_RST_VAL;
      end else begin
         if (wr_en) enable_r <= I_WDATA;
         if (wr_oe) outen_r  <= I_WDATA;
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         pending_r  <= BCIRQ_RST_VAL;
         log_wr_r   <= 1'b0;
         log_bits_r <= BCIRQ_RST_VAL;
         rdata_r    <= BCIRQ_RST_VAL;
      end else begin
         pending_r  <= pending_nxt;
         log_wr_r   <= log_wr_nxt;
         log_bits_r <= ev;
         rdata_r    <= rdata_nxt;
      end
   end

   // Queue pointer tracks the circular queue position
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         gpq_ptr_r <= PTR_BASE;
      end else begin
         gpq_ptr_r <= gpq_ptr_nxt;
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         summary_r <= 1'b0;
      end else begin
         summary_r <= summary_nxt;
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // shared interrupt line
   // Other sources arrive already gated by their own output-enable registers
   assign O_IRQ                        = irq_r | I_OTHER_IRQ;
   assign O_RDATA                      = rdata_r;
   assign O_LOG_WRITE                  = log_wr_r;
   assign O_LOG_BITS                   = log_bits_r;
   assign O_CONTROLLER_SUMMARY_PENDING = summary_r;

endmodule
`default_nettype wire

// File: tb_top.sv
// Purpose: Self-checking bench of bcirq_regs
// Assumes: Queue depth shortened to 4
// Notes:   Model pending word kept in pend
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 0, rst = 1, fr = 0, dn = 0, gq = 0, oirq = 0, w, r, lw, sp, irq;
   logic [15:0] cw = 0, wd, rdat, lb, pend = 0, en = 0;
   logic [12:0] oth = 0;
   logic [7:0]  a;
   logic [31:0] s = 34046;
   int n_errors = 0, cmp_count = 0, i, gp = 0;
   always #50 clk = ~clk;
   bcirq_host host_u (.clk(clk), .addr(a), .wr(w), .rd(r), .wdata(wd));
   bcirq_regs #(.GPQ_DEPTH(4)) dut_u (.I_CLOCK(clk), .I_RST(rst), .I_ADDR(a), .I_WR(w),
      .I_RD(r), .I_WDATA(wd), .O_RDATA(rdat), .I_FRAME_TIMER_EXPIRED(fr), .I_MSG_DONE(dn),
      .I_MSG_CTRL_WORD(cw), .I_GPQ_PTR_ADVANCE(gq), .I_OTHER_EVENTS(oth), .I_OTHER_IRQ(oirq),
      .O_LOG_WRITE(lw), .O_LOG_BITS(lb), .O_CONTROLLER_SUMMARY_PENDING(sp), .O_IRQ(irq));
   task automatic chk(input logic [15:0] g, e);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Read pending against the model, which then clears
   task automatic rp();
      host_u.acc(0, 8'h07, 0);
      chk(rdat, pend);
      pend = 0;
   endtask
   // One-cycle event; wrap counted from the shortened depth
   task automatic ev(input logic f, d, q, input logic [15:0] c, input logic [12:0] o);
      logic [15:0] b;
      @(negedge clk) {fr, dn, gq, cw, oth} = {f, d, q, c, o};
      gp = (gp + q) % 4;
      b = {f, d & c[4], q && gp == 0, o} & en;
      pend |= b;
      @(negedge clk) {fr, dn, gq, oth} = 0;
      chk({15'h0, lw}, {15'h0, |b});
      if (|b) chk(lb, b);
   endtask
   // Xorshift source for all random stimulus
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
   endfunction
   task automatic close_out();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #1000000 n_errors++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge clk);
      @(negedge clk) rst = 0;
      ev(1, 1, 1, 16'h0010, 13'h1FFF);
      for (i = 8'h10; i <= 8'h14; i += 4) begin
         s = xs(s);
         host_u.acc(1, i, s);
         host_u.acc(0, i, 0);
         chk(rdat, s[15:0]);
      end
      host_u.acc(1, 8'h14, 0);
      host_u.acc(1, 8'h10, 16'hFFFF);
      host_u.acc(1, 8'h07, 16'hFFFF);
      en = 16'hFFFF;
      rp();
      for (i = 0; i < 6; i++) begin
         s = xs(s);
         ev(s[3], s[7], 1, s[15:0], s[28:16]);
      end
      chk({15'h0, irq}, 0);
      rp();
      rp();
      host_u.acc(0, 8'h33, 0);
      chk(rdat, 0);
      host_u.acc(1, 8'h14, 16'hC000);
      ev(1, 0, 0, 0, 0);
      chk({15'h0, irq}, 0);
      chk({15'h0, sp}, 1);
      ev(0, 1, 0, 0, 0);
      chk({15'h0, irq}, 1);
      rp();
      repeat (2) @(negedge clk);
      chk({14'h0, irq, sp}, 0);
      oirq = 1;
      @(posedge clk);
      chk({15'h0, irq}, 1);
      @(negedge clk) oirq = 0;
      close_out();
   end
endmodule
`default_nettype wire
